// ==== bench/lp4_ctrl_model.sv ====
// lp4_ctrl_model.sv: controller model driving the link clock and command pins
`timescale 1ns/10ps
`default_nettype none
`include "lp4_defines.svh"
module lp4_ctrl_model (
    // clocks
    input wire logic ref_clk,
    output logic ck_t,
    output logic ck_c,
    // command pins
    output logic cke,
    output logic cs,
    output logic [`LP4_CA_W-1:0] ca
);
    initial ck_t = 1'b0;
    initial cke = 1'b1;
    initial cs = 1'b0;
    initial ca = 6'h00;
    always #16 ck_t = ~ck_t;
    assign ck_c = ~ck_t;
    // pins change mid-cycle so the device sees them settled at the rise
    task send(input logic c, input logic [5:0] a);
        @(negedge ck_t);
        @(posedge ref_clk);
        cs <= c;
        ca <= a;
    endtask
    task settle;
        @(posedge ck_t);
        repeat (6) @(posedge ref_clk);
    endtask
    // cke stays high while any command is on the pins
    task cmd(input logic [5:0] a1, input logic [5:0] a2);
        send(1'b1, a1);
        send(1'b0, a2);
        send(1'b0, a2);
        settle;
    endtask
    task set_cke(input logic v);
        @(negedge ck_t);
        @(posedge ref_clk);
        cke <= v;
    endtask
endmodule // lp4_ctrl_model
`default_nettype wire

// ==== bench/tb.sv ====
// tb.sv: self-checking bench for the channel pin interface
`timescale 1ns/10ps
`default_nettype none
`include "lp4_defines.svh"
module tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic term_pin = 1'b0;
    logic odt_en = 1'b0;
    logic [`LP4_BURST*`LP4_DQ_W-1:0] rd_data = '0;
    logic ck_t, ck_c, cke, cs, dq_oe_n, dqs_oe_n, dmi_oe_n, ca_term_on, rd_req;
    logic [5:0] ca;
    logic [15:0] dq_o;
    logic [1:0] dqs_o, dqs_c_o;
    lp4_pkg::lp4_state_e bus_state;
    logic [7:0] banks_open;
    logic wr_inv_en = 1'b0;
    logic [15:0] dq_in = '0;
    logic [1:0] dqs_in = '0;
    logic [1:0] dmi_in = '0;
    logic [1:0] dmi_o;
    logic wr_valid;
    lp4_pkg::lp4_wr_s wr_out;
    logic [2:0] rd_bank;
    logic [9:0] rd_col;
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int rd_cnt = 0;
    always #2 ref_clk = ~ref_clk;
    lp4_ctrl_model i_lp4_ctrl_model (.ref_clk(ref_clk), .ck_t(ck_t), .ck_c(ck_c), .cke(cke), .cs(cs), .ca(ca));
    // read inversion rides on the always-high enable; write masking stays off
    lp4_channel #(.READ_LAT(2)) i_lp4_channel (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
        .ck_t(ck_t), .ck_c(ck_c), .cke(cke), .cs(cs), .cmd_addr_bus(ca), .termination_control_pin(term_pin),
        .dq_i(dq_in), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dqs_i(dqs_in), .dqs_o(dqs_o), .dqs_c_o(dqs_c_o),
        .dqs_oe_n(dqs_oe_n), .mask_invert_line_i(dmi_in), .mask_invert_line_o(dmi_o),
        .mask_invert_line_oe_n(dmi_oe_n),
        .bus_inversion_rd_en(clk_en), .bus_inversion_wr_en(wr_inv_en), .write_mask_en(1'b0), .ca_odt_en(odt_en),
        .ca_term_on(ca_term_on), .bus_state(bus_state), .banks_open(banks_open), .rd_req(rd_req),
        .rd_bank(rd_bank), .rd_col(rd_col), .rd_data(rd_data), .wr_valid(wr_valid), .wr_out(wr_out));
    always @(posedge ref_clk) if (rd_req === 1'b1) rd_cnt++;
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            final_report;
        end
    end
    task t_reset_idle;
        check({dq_oe_n, dqs_oe_n, dmi_oe_n}, 3'h7);
        check(bus_state, lp4_pkg::st_reset);
        rst_n <= 1'b1;
        i_lp4_ctrl_model.settle;
        i_lp4_ctrl_model.settle;
        check(bus_state, lp4_pkg::st_idle);
    endtask
    task t_act_pre;
        i_lp4_ctrl_model.cmd(6'h01, 6'h03); // row top bits kept low
        i_lp4_ctrl_model.cmd(6'h03, 6'h00);
        check(banks_open, 8'h08);
        check(bus_state, lp4_pkg::st_active);
        i_lp4_ctrl_model.cmd(6'h30, 6'h00);
        check({banks_open, bus_state}, {8'h00, lp4_pkg::st_idle});
    endtask
    task t_read;
        int n;
        n = 0;
        rd_data[31:0] <= 32'h12ff_1234;
        i_lp4_ctrl_model.cmd(6'h01, 6'h05);
        i_lp4_ctrl_model.cmd(6'h03, 6'h00);
        i_lp4_ctrl_model.send(1'b1, 6'h02);
        i_lp4_ctrl_model.send(1'b0, 6'h15);
        i_lp4_ctrl_model.cmd(6'h32, 6'h3f);
        check({rd_cnt[3:0], rd_bank, rd_col}, {4'h1, 3'h5, 10'h3fc});
        while (dq_oe_n !== 1'b0 && n < 400) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check({dq_oe_n, dq_o, dmi_o}, {1'b0, 16'h1234, 2'b00});
        check({dqs_oe_n, dqs_o, dqs_c_o}, {1'b0, 2'b11, 2'b00});
        while (dqs_o !== 2'b00 && n < 400) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check({dq_o, dmi_o, dqs_c_o}, {16'h1200, 2'b01, 2'b11});
        i_lp4_ctrl_model.cmd(6'h30, 6'h00);
    endtask
    task t_mode;
        i_lp4_ctrl_model.cmd(6'h18, 6'h00);
        check(bus_state, lp4_pkg::st_sref);
        i_lp4_ctrl_model.send(1'b1, 6'h06);
        i_lp4_ctrl_model.send(1'b0, 6'h00);
        i_lp4_ctrl_model.cmd(6'h16, 6'h00);
        check(bus_state, lp4_pkg::st_sref);
        for (int i = 0; i < 2; i++) begin
            i_lp4_ctrl_model.send(1'b1, 6'h06);
            i_lp4_ctrl_model.send(1'b0, 6'h0e);
            i_lp4_ctrl_model.cmd(6'h16, 6'(1 - i));
            check(bus_state, i ? lp4_pkg::st_hold : lp4_pkg::st_train);
        end
        i_lp4_ctrl_model.cmd(6'h30, 6'h00);
        check(bus_state, lp4_pkg::st_idle);
    endtask
    task t_write;
        int n;
        n = 0;
        dmi_in <= 2'b10;
        wr_inv_en <= 1'b1;
        i_lp4_ctrl_model.cmd(6'h01, 6'h02);
        i_lp4_ctrl_model.cmd(6'h03, 6'h00);
        i_lp4_ctrl_model.send(1'b1, 6'h04);
        i_lp4_ctrl_model.send(1'b0, 6'h02);
        i_lp4_ctrl_model.cmd(6'h12, 6'h00);
        for (int b = 0; b < 16; b++) begin
            // lane 1 travels inverted; data settles before its strobe edge
            dq_in <= {~8'(b), 8'(b)};
            @(posedge ref_clk);
            dqs_in <= ~dqs_in;
            repeat (3) @(posedge ref_clk);
        end
        while (wr_valid !== 1'b1 && n < 40) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check({wr_valid, wr_out.bank, wr_out.col}, {1'b1, 3'h2, 10'h000});
        check({wr_out.data[31:16], wr_out.data[255:240]}, {16'h0101, 16'h0f0f});
        check(wr_out.mask, 32'h0);
    endtask
    task t_term;
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            {term_pin, odt_en} <= i[1:0];
            repeat (6) @(posedge ref_clk);
            check(ca_term_on, i[1] & i[0]);
        end
    endtask
    task t_cke_reset;
        i_lp4_ctrl_model.set_cke(1'b0);
        i_lp4_ctrl_model.settle;
        check(bus_state, lp4_pkg::st_pdn);
        rst_n <= 1'b0;
        @(posedge ref_clk);
        #1;
        check({dq_oe_n, bus_state}, {1'b1, lp4_pkg::st_reset});
        i_lp4_ctrl_model.set_cke(1'b1);
        t_reset_idle;
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        t_reset_idle;
        t_act_pre;
        t_read;
        t_mode;
        t_write;
        t_term;
        t_cke_reset;
        final_report;
    end
endmodule // tb
`default_nettype wire

// ==== inc/lp4_defines.svh ====
// lp4_defines.svh: constants for the channel pin interface
// Summary of operation
// - six command/address lines carry every command, address and bank, over several cycles
// - commands take 1 or 2 cycles, captured on rising clock edges only
// - command inputs are sampled where the true clock rises and the complement falls; write data is taken on strobe edges
// - two data words per cycle on both edges, sixteen-word burst per access
// - clock gate high runs the interface; low stops it and enters power-down from idle, active or self refresh
// - chip select is part of each command code, per channel
// - on reads the device drives each lane strobe, edge-aligned with data
// - mask/inversion line high means the lane data is inverted; can be disabled
// - mask/inversion line acts as inversion or write mask per mode setting
// - the active-low reset resets the whole channel while low
// - reset is accepted in any state and leads to the reset state
// - command/address termination follows the control pin and its mode setting
// - eight banks on three bits, fifteen row bits, ten column bits
// - two lowest column bits are never sent and are taken as zero
// - idle is entered only with every bank precharged
// - training entered by mode write or multi-purpose command does not return to idle
// - automatic-return states go back to the state that entered them
// - from self refresh, power-down, mode read, mode write and multi-purpose are allowed
// - all commands but deselect span two cycles, decoded at the first rising edge
`ifndef LP4_DEFINES_SVH
`define LP4_DEFINES_SVH
`define LP4_CA_W 6
`define LP4_DQ_W 16
`define LP4_BANK_W 3
`define LP4_COL_W 10
`define LP4_BURST 16
`define LP4_READ_LAT 6
`define LP4_DBI_MAX 4'h4
`define LP4_TRAIN_MA 6'h0e
`define LP4_MPC_TRAIN_BIT 6
`define LP4_SYNC_W 31
`endif

// ==== inc/lp4_pkg.sv ====
// lp4_pkg.sv: types for the channel pin interface
`include "lp4_defines.svh"
package lp4_pkg;
    typedef enum logic [2:0] {
        st_reset, st_idle, st_active, st_sref, st_pdn, st_mode, st_train, st_hold
    } lp4_state_e;
    typedef enum logic [3:0] {
        cmd_des, cmd_mpc, cmd_pre, cmd_ref, cmd_sre, cmd_wr, cmd_srx, cmd_mwr,
        cmd_rd, cmd_cas2, cmd_mrw1, cmd_mrw2, cmd_mrr, cmd_act1, cmd_act2, cmd_rfu
    } lp4_cmd_e;
    typedef struct packed {
        logic cke;
        logic cs;
        logic [`LP4_CA_W-1:0] ca;
    } lp4_ca_s;
    typedef struct packed {
        logic [`LP4_BANK_W-1:0] bank;
        logic [`LP4_COL_W-1:0] col;
        logic [`LP4_BURST*`LP4_DQ_W-1:0] data;
        logic [`LP4_BURST*2-1:0] mask;
    } lp4_wr_s;
endpackage

// ==== verilog/lp4_channel.sv ====
// lp4_channel.sv: one memory channel seen from its pins
`timescale 1ns/10ps
`default_nettype none
`include "lp4_defines.svh"
module lp4_channel #(
    parameter int READ_LAT = `LP4_READ_LAT
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // command pins
    input wire logic ck_t,
    input wire logic ck_c,
    input wire logic cke,
    input wire logic cs,
    input wire logic [`LP4_CA_W-1:0] cmd_addr_bus,
    input wire logic termination_control_pin,
    // data pins
    input wire logic [`LP4_DQ_W-1:0] dq_i,
    output logic [`LP4_DQ_W-1:0] dq_o,
    output logic dq_oe_n,
    input wire logic [1:0] dqs_i,
    output logic [1:0] dqs_o,
    output logic [1:0] dqs_c_o,
    output logic dqs_oe_n,
    input wire logic [1:0] mask_invert_line_i,
    output logic [1:0] mask_invert_line_o,
    output logic mask_invert_line_oe_n,
    // mode settings
    input wire logic bus_inversion_rd_en,
    input wire logic bus_inversion_wr_en,
    input wire logic write_mask_en,
    input wire logic ca_odt_en,
    // status
    output logic ca_term_on,
    output lp4_pkg::lp4_state_e bus_state,
    output logic [7:0] banks_open,
    // user side
    output logic rd_req,
    output logic [`LP4_BANK_W-1:0] rd_bank,
    output logic [`LP4_COL_W-1:0] rd_col,
    input wire logic [`LP4_BURST*`LP4_DQ_W-1:0] rd_data,
    output logic wr_valid,
    output lp4_pkg::lp4_wr_s wr_out
);
    function automatic lp4_pkg::lp4_cmd_e lp4_decode(input logic [5:0] c);
        if (c[0]) begin
            return c[1] ? lp4_pkg::cmd_act2 : lp4_pkg::cmd_act1;
        end
        case ({c[1], c[2], c[3], c[4]})
            4'h0: return lp4_pkg::cmd_mpc;
            4'h1: return lp4_pkg::cmd_pre;
            4'h2: return lp4_pkg::cmd_ref;
            4'h3: return c[5] ? lp4_pkg::cmd_rfu : lp4_pkg::cmd_sre;
            4'h4: return lp4_pkg::cmd_wr;
            4'h5: return lp4_pkg::cmd_srx;
            4'h6: return lp4_pkg::cmd_mwr;
            4'h8: return lp4_pkg::cmd_rd;
            4'h9: return lp4_pkg::cmd_cas2;
            4'hc: return lp4_pkg::cmd_mrw1;
            4'hd: return lp4_pkg::cmd_mrw2;
            4'he: return lp4_pkg::cmd_mrr;
            default: return lp4_pkg::cmd_rfu;
        endcase
    endfunction

    function automatic logic [3:0] lp4_ones(input logic [7:0] b);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, b[i]};
        end
        return n;
    endfunction

    // pin synchroniser; stage 3 only feeds edge detection
    logic [`LP4_SYNC_W-1:0] s1_reg, s2_reg;
    logic [3:0] s3_reg;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else if (clk_en) begin
            s1_reg <= {ck_t, ck_c, cke, cs, cmd_addr_bus, termination_control_pin,
                       mask_invert_line_i, dqs_i, dq_i};
            s2_reg <= s1_reg;
            s3_reg <= {s2_reg[30:29], s2_reg[17:16]};
        end
    end

    lp4_pkg::lp4_ca_s ca_now;
    // a rise also needs the complement seen high before, so the zeroed stages give no false rise after reset
    wire ck_rise = clk_en & s2_reg[30] & ~s3_reg[3] & ~s2_reg[29] & s3_reg[2];
    wire ck_fall = clk_en & ~s2_reg[30] & s3_reg[3];
    wire [1:0] dqs_edge = {2{clk_en}} & (s2_reg[17:16] ^ s3_reg[1:0]);
    wire [1:0] dmi_s = s2_reg[19:18];
    wire [15:0] dq_s = s2_reg[15:0];
    assign ca_now = '{cke: s2_reg[28], cs: s2_reg[27], ca: s2_reg[26:21]};

    // command decode and bus state
    lp4_pkg::lp4_state_e state_reg, state_next, ret_reg, ret_next;
    lp4_pkg::lp4_cmd_e pend_reg, pend_next, cas_reg, cas_next;
    logic [5:0] first_reg, first_next, ma_reg, ma_next;
    logic [7:0] banks_reg, banks_next;
    logic [2:0] cbank_reg, cbank_next;
    logic c9_reg, c9_next, ap_reg, ap_next, op7_reg, op7_next, rd_go, wr_go;
    logic [`LP4_COL_W-1:0] col_w;
    wire [7:0] mrw_op = {op7_reg, first_reg[5], ca_now.ca};
    wire [6:0] mpc_op = {first_reg[5], ca_now.ca};
    wire can_mode = state_reg inside {lp4_pkg::st_idle, lp4_pkg::st_active, lp4_pkg::st_sref};
    assign col_w = {c9_reg, first_reg[5], ca_now.ca, 2'b00};

    always_comb begin
        state_next = state_reg;
        ret_next = ret_reg;
        pend_next = pend_reg;
        first_next = first_reg;
        banks_next = banks_reg;
        cas_next = cas_reg;
        cbank_next = cbank_reg;
        c9_next = c9_reg;
        ap_next = ap_reg;
        ma_next = ma_reg;
        op7_next = op7_reg;
        rd_go = 1'b0;
        wr_go = 1'b0;
        if (ck_rise) begin
            if (state_reg == lp4_pkg::st_reset) begin
                state_next = lp4_pkg::st_idle;
            end else if (state_reg == lp4_pkg::st_mode) begin
                state_next = ret_reg;
            end else if (!ca_now.cke) begin
                pend_next = lp4_pkg::cmd_des;
                if (can_mode) begin
                    ret_next = state_reg;
                    state_next = lp4_pkg::st_pdn;
                end
            end else if (state_reg == lp4_pkg::st_pdn) begin
                state_next = ret_reg;
            end else if (pend_reg == lp4_pkg::cmd_des) begin
                if (ca_now.cs) begin
                    pend_next = lp4_decode(ca_now.ca);
                    first_next = ca_now.ca;
                end
            end else begin
                pend_next = lp4_pkg::cmd_des;
                case (pend_reg)
                    lp4_pkg::cmd_act1: cbank_next = ca_now.ca[2:0];
                    lp4_pkg::cmd_act2: begin
                        if (state_reg inside {lp4_pkg::st_idle, lp4_pkg::st_active}) begin
                            banks_next[cbank_reg] = 1'b1;
                            state_next = lp4_pkg::st_active;
                        end
                    end
                    lp4_pkg::cmd_pre: begin
                        if (first_reg[5]) begin
                            banks_next = 8'h00;
                        end else begin
                            banks_next[ca_now.ca[2:0]] = 1'b0;
                        end
                        if (banks_next == 8'h00 &&
                            state_reg inside {lp4_pkg::st_active, lp4_pkg::st_hold}) begin
                            state_next = lp4_pkg::st_idle;
                        end
                    end
                    lp4_pkg::cmd_sre: begin
                        if (state_reg == lp4_pkg::st_idle) begin
                            state_next = lp4_pkg::st_sref;
                        end
                    end
                    lp4_pkg::cmd_srx: begin
                        if (state_reg == lp4_pkg::st_sref) begin
                            state_next = lp4_pkg::st_idle;
                        end
                    end
                    lp4_pkg::cmd_wr, lp4_pkg::cmd_mwr, lp4_pkg::cmd_rd: begin
                        cas_next = pend_reg;
                        cbank_next = ca_now.ca[2:0];
                        c9_next = ca_now.ca[4];
                        ap_next = ca_now.ca[5];
                    end
                    lp4_pkg::cmd_cas2: begin
                        rd_go = cas_reg == lp4_pkg::cmd_rd;
                        wr_go = cas_reg inside {lp4_pkg::cmd_wr, lp4_pkg::cmd_mwr};
                        cas_next = lp4_pkg::cmd_des;
                        if (ap_reg && (rd_go || wr_go)) begin
                            banks_next[cbank_reg] = 1'b0;
                        end
                    end
                    lp4_pkg::cmd_mrw1: begin
                        ma_next = ca_now.ca;
                        op7_next = first_reg[5];
                    end
                    lp4_pkg::cmd_mrw2: begin
                        if (ma_reg == `LP4_TRAIN_MA && mrw_op[0]) begin
                            state_next = lp4_pkg::st_train;
                        end else if (state_reg == lp4_pkg::st_train) begin
                            state_next = lp4_pkg::st_hold;
                        end else if (can_mode) begin
                            ret_next = state_reg;
                            state_next = lp4_pkg::st_mode;
                        end
                    end
                    lp4_pkg::cmd_mpc: begin
                        if (mpc_op[`LP4_MPC_TRAIN_BIT]) begin
                            state_next = lp4_pkg::st_train;
                        end else if (state_reg == lp4_pkg::st_train) begin
                            state_next = lp4_pkg::st_hold;
                        end else if (can_mode) begin
                            ret_next = state_reg;
                            state_next = lp4_pkg::st_mode;
                        end
                    end
                    lp4_pkg::cmd_mrr: begin
                        if (can_mode) begin
                            ret_next = state_reg;
                            state_next = lp4_pkg::st_mode;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // reset clears everything and ignores the pins while held
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= lp4_pkg::st_reset;
            ret_reg <= lp4_pkg::st_idle;
            pend_reg <= lp4_pkg::cmd_des;
            cas_reg <= lp4_pkg::cmd_des;
            first_reg <= '0;
            banks_reg <= '0;
            cbank_reg <= '0;
            c9_reg <= 1'b0;
            ap_reg <= 1'b0;
            ma_reg <= '0;
            op7_reg <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            ret_reg <= ret_next;
            pend_reg <= pend_next;
            cas_reg <= cas_next;
            first_reg <= first_next;
            banks_reg <= banks_next;
            cbank_reg <= cbank_next;
            c9_reg <= c9_next;
            ap_reg <= ap_next;
            ma_reg <= ma_next;
            op7_reg <= op7_next;
        end
    end

    // read path: latency in link cycles, then one word per link edge
    logic rd_wait_reg, rd_act_reg, rd_req_reg, wr_act_reg, wr_mwr_reg, wr_valid_reg, term_reg, drv_reg;
    logic [3:0] lat_reg, beat_reg;
    logic [4:0] wbeat_reg [2];
    logic [`LP4_BURST*`LP4_DQ_W-1:0] rd_buf_reg;
    logic [15:0] dq_o_reg;
    logic [1:0] dqs_o_reg, dmi_o_reg;
    logic [`LP4_COL_W-1:0] rd_col_reg;
    logic [2:0] rd_bank_reg;
    lp4_pkg::lp4_wr_s wr_reg;
    wire lk_edge = ck_rise | ck_fall;
    wire [15:0] rd_word = rd_buf_reg[beat_reg*16 +: 16];
    wire [1:0] rd_inv = {2{bus_inversion_rd_en}} &
                        {lp4_ones(rd_word[15:8]) > `LP4_DBI_MAX, lp4_ones(rd_word[7:0]) > `LP4_DBI_MAX};
    wire wr_done = wbeat_reg[0][4] & wbeat_reg[1][4];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_wait_reg <= 1'b0;
            rd_act_reg <= 1'b0;
            rd_req_reg <= 1'b0;
            drv_reg <= 1'b0;
            lat_reg <= '0;
            beat_reg <= '0;
            rd_buf_reg <= '0;
            dq_o_reg <= '0;
            dqs_o_reg <= '0;
            dmi_o_reg <= '0;
            rd_col_reg <= '0;
            rd_bank_reg <= '0;
        end else if (clk_en) begin
            rd_req_reg <= rd_go & ~rd_wait_reg & ~rd_act_reg;
            if (rd_go && !rd_wait_reg && !rd_act_reg) begin
                rd_wait_reg <= 1'b1;
                lat_reg <= 4'(READ_LAT);
                rd_col_reg <= col_w;
                rd_bank_reg <= cbank_reg;
            end else if (rd_wait_reg && ck_rise) begin
                lat_reg <= lat_reg - 4'h1;
                if (lat_reg == 4'h1) begin
                    rd_wait_reg <= 1'b0;
                    rd_act_reg <= 1'b1;
                    rd_buf_reg <= rd_data;
                    beat_reg <= '0;
                end
            end else if (rd_act_reg && lk_edge) begin
                dq_o_reg <= rd_word ^ {{8{rd_inv[1]}}, {8{rd_inv[0]}}};
                dmi_o_reg <= rd_inv;
                dqs_o_reg <= {2{~beat_reg[0]}};
                drv_reg <= 1'b1;
                beat_reg <= beat_reg + 4'h1;
                rd_act_reg <= beat_reg != 4'(`LP4_BURST - 1);
            end else if (!rd_act_reg && ck_fall) begin
                dqs_o_reg <= '0;
            end
            // the last word stands for one link edge before the drivers let go
            if (lk_edge && !rd_act_reg) begin
                drv_reg <= 1'b0;
            end
        end
    end

    // write path: each lane counts its own strobe edges
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_act_reg <= 1'b0;
            wr_mwr_reg <= 1'b0;
            wr_valid_reg <= 1'b0;
            wr_reg <= '0;
            wbeat_reg[0] <= '0;
            wbeat_reg[1] <= '0;
            term_reg <= 1'b0;
        end else if (clk_en) begin
            term_reg <= s2_reg[20] & ca_odt_en;
            wr_valid_reg <= wr_act_reg & wr_done;
            if (wr_go && !wr_act_reg) begin
                wr_act_reg <= 1'b1;
                wr_mwr_reg <= cas_reg == lp4_pkg::cmd_mwr;
                wr_reg.bank <= cbank_reg;
                wr_reg.col <= col_w;
                wbeat_reg[0] <= '0;
                wbeat_reg[1] <= '0;
            end else if (wr_act_reg && wr_done) begin
                wr_act_reg <= 1'b0;
            end else if (wr_act_reg) begin
                for (int l = 0; l < 2; l++) begin
                    if (dqs_edge[l] && !wbeat_reg[l][4]) begin
                        wr_reg.mask[wbeat_reg[l]*2 + l] <= write_mask_en & wr_mwr_reg & dmi_s[l];
                        wr_reg.data[wbeat_reg[l]*16 + l*8 +: 8] <= dq_s[l*8 +: 8] ^
                            {8{bus_inversion_wr_en & ~(write_mask_en & wr_mwr_reg) & dmi_s[l]}};
                        wbeat_reg[l] <= wbeat_reg[l] + 5'h01;
                    end
                end
            end
        end
    end

    // drivers stay off in reset and while the clock gate is low
    // enable follows the words really on the pins, so no stale word leads the burst
    assign dq_oe_n = ~drv_reg | ~ca_now.cke;
    assign dqs_oe_n = dq_oe_n;
    assign mask_invert_line_oe_n = dq_oe_n;
    assign dq_o = dq_o_reg;
    assign dqs_o = dqs_o_reg;
    assign dqs_c_o = ~dqs_o_reg;
    assign mask_invert_line_o = dmi_o_reg;
    assign ca_term_on = term_reg;
    assign bus_state = state_reg;
    assign banks_open = banks_reg;
    assign rd_req = rd_req_reg;
    assign rd_col = rd_col_reg;
    assign rd_bank = rd_bank_reg;
    assign wr_valid = wr_valid_reg;
    assign wr_out = wr_reg;

    property p_rise_only;
        @(posedge ref_clk) disable iff (!rst_n) !ck_rise |=> $stable(pend_reg);
    endproperty
    a_rise_only: assert property (p_rise_only) else $error("command taken off a rising edge");
    property p_idle_closed;
        @(posedge ref_clk) disable iff (!rst_n) state_reg == lp4_pkg::st_idle |-> banks_reg == 8'h00;
    endproperty
    a_idle_closed: assert property (p_idle_closed) else $error("idle with open bank");
    property p_reset_quiet;
        @(posedge ref_clk) disable iff (!rst_n) state_reg == lp4_pkg::st_reset |-> dq_oe_n && !rd_req;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("driving in reset state");
    property p_pdn_entry;
        @(posedge ref_clk) disable iff (!rst_n)
            ck_rise && !ca_now.cke && state_reg == lp4_pkg::st_idle |=> state_reg == lp4_pkg::st_pdn;
    endproperty
    a_pdn_entry: assert property (p_pdn_entry) else $error("no power-down on gate low");
    property p_strobe_edge;
        @(posedge ref_clk) disable iff (!rst_n)
            clk_en && rd_act_reg && lk_edge |=> dqs_o != $past(dqs_o) && dq_oe_n == !ca_now.cke;
    endproperty
    a_strobe_edge: assert property (p_strobe_edge) else $error("strobe not moved with data");
    property p_train_exit;
        @(posedge ref_clk) disable iff (!rst_n)
            $past(state_reg) == lp4_pkg::st_train && state_reg != lp4_pkg::st_train |-> state_reg == lp4_pkg::st_hold;
    endproperty
    a_train_exit: assert property (p_train_exit) else $error("training returned to idle");
    property p_mode_return;
        @(posedge ref_clk) disable iff (!rst_n)
            state_reg == lp4_pkg::st_mode && ck_rise |=> state_reg == $past(ret_reg);
    endproperty
    a_mode_return: assert property (p_mode_return) else $error("mode state returned elsewhere");
    property p_term;
        @(posedge ref_clk) disable iff (!rst_n)
            (rst_n && clk_en && ca_odt_en && termination_control_pin)[*4] |-> ca_term_on;
    endproperty
    a_term: assert property (p_term) else $error("termination not switched on");
    property p_col_zero;
        @(posedge ref_clk) disable iff (!rst_n) rd_req |-> rd_col[1:0] == 2'b00 ##[1:300] rd_act_reg;
    endproperty
    a_col_zero: assert property (p_col_zero) else $error("read start or column bits wrong");
    c_read: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(rd_act_reg));
    c_write: cover property (@(posedge ref_clk) disable iff (!rst_n) wr_valid);
    c_sref: cover property (@(posedge ref_clk) disable iff (!rst_n) state_reg == lp4_pkg::st_sref);
    c_train: cover property (@(posedge ref_clk) disable iff (!rst_n) state_reg == lp4_pkg::st_hold);
endmodule // lp4_channel
`default_nettype wire
